// ===== hdl/evbrk_pkg.sv
package evbrk_pkg;
    localparam int NUM_CMB = 4;
    localparam int NUM_BP = 8;
    localparam int NUM_EV = 3;
    localparam int NUM_SRC = 16;
    localparam int MAX_MEMB = 8;
    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_EV_ACT = 8'h04;
    localparam logic [7:0] OFF_BP_ACT = 8'h08;
    localparam logic [7:0] OFF_PMEM = 8'h0C;
    localparam logic [7:0] OFF_CMB0 = 8'h10;
    localparam logic [7:0] OFF_PREV_PC = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h24;
    localparam logic [7:0] OFF_MASK = 8'h28;
    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int C_TIN_NEG = 0;
    localparam int C_FILT_EN = 1;
    localparam int C_TOUT_NEG = 2;
    localparam int C_ONESHOT = 3;
    localparam int C_FORCE = 4;
    localparam int C_MASTER_CLEAR_RESET_PIN_EN = 5;
    localparam int C_OOB_EN = 6;
    localparam int C_TIN_EN = 7;
    localparam int ACT_HALT = 0;
    localparam int ACT_TRIG = 1;
    localparam int SRC_MASTER_CLEAR_RESET_PIN = 8;
    localparam int SRC_OOB = 9;
    localparam int SRC_TIN = 10;
    localparam int SRC_CMB = 12;
    localparam int CMB_MODE = 16;
    localparam int CMB_ACT = 17;
    localparam int CMB_W = 19;
    localparam int ST_EV = 0;
    localparam int ST_CMB = 3;
    localparam int ST_HALT = 7;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [5:0] EV_ACT_RST = 6'h00;
    localparam logic [15:0] BP_ACT_RST = 16'h0000;
    localparam logic [15:0] PMEM_RST = 16'h4000;
    localparam logic [CMB_W-1:0] CMB_RST = 19'h0_0000;
    localparam logic [7:0] MASK_RST = 8'h00;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_NS = 40;
    localparam int ONESHOT_NS = 1000;
    localparam int FILTER_NS = 200;
    localparam int ONESHOT_CYC = (ONESHOT_NS + CLK_NS - 1) / CLK_NS;
    localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int SHOT_W = $clog2(ONESHOT_CYC + 1);
    localparam int FILT_W = $clog2(FILTER_CYC + 1);
    typedef enum logic [2:0] {
        TO_IDLE = 3'b001,
        TO_SHOT = 3'b010,
        TO_LEVEL = 3'b100
    } tout_state_t;
endpackage

// ===== hdl/cmb_if.sv
`timescale 1ns/10ps
interface cmb_if;
    logic [15:0] members;
    logic mode_and;
    logic [15:0] src;
    logic restart;
    logic fire;
    modport ctl(output members, mode_and, src, restart, input fire);
    modport unit(input members, mode_and, src, restart, output fire);
endinterface

// ===== hdl/cmb_unit.sv
`timescale 1ns/10ps
module cmb_unit (
    input wire logic clk_i,
    input wire logic rst_n_i,
    cmb_if.unit bus
);
    logic [15:0] done;
    logic [15:0] next_done;
    logic fire;
    logic next_fire;
    logic [15:0] hits;
    logic [15:0] pend;
    logic [15:0] want;
    logic [15:0] acc;

    assign bus.fire = fire;

    always_comb begin
        hits = bus.src & bus.members;
        pend = bus.members & ~done;
        // lowest pending member is the next one due
        want = pend & (~pend + 16'h0001);
        acc = done;
        next_done = done;
        next_fire = 1'b0;
        if (bus.restart || bus.members == 16'h0000) begin
            next_done = 16'h0000;
        end else if (bus.mode_and) begin
            acc = done | hits;
            if (acc == bus.members) begin
                next_fire = 1'b1;
                next_done = 16'h0000;
            end else begin
                next_done = acc;
            end
        end else if ((hits & want) != 16'h0000) begin
            acc = done | want;
            if (acc == bus.members) begin
                next_fire = 1'b1;
                next_done = 16'h0000;
            end else begin
                next_done = acc;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done <= 16'h0000;
            fire <= 1'b0;
        end else begin
            done <= next_done;
            fire <= next_fire;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_and_fire: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        bus.mode_and && !bus.restart && bus.members != 16'h0000
        && (done | hits) == bus.members |=> fire)
        else $error("latched and did not fire");
    chk_seq_quiet: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !bus.mode_and && (hits & want) == 16'h0000 |=> !fire)
        else $error("sequence fired without its next member");
    chk_seq_order: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        !bus.mode_and && $stable(bus.members) && want != 16'h0000
        |-> (done & ~(want - 16'h0001)) == 16'h0000)
        else $error("sequence progress out of order");
    chk_restart_clr: assert property (
        @(posedge clk_i) disable iff (!rst_n_i)
        bus.restart |=> done == 16'h0000 && !fire)
        else $error("restart left progress");
    cov_seq_fire: cover property (
        @(posedge clk_i) disable iff (!rst_n_i)
        fire && !bus.mode_and && $past(done) != 16'h0000);
    cov_and_fire: cover property (
        @(posedge clk_i) disable iff (!rst_n_i)
        fire && bus.mode_and);
endmodule // cmb_unit

// ===== hdl/evbrk_top.sv
// Behaviour
// - master clear, out-of-bounds execution and trigger in are events.
// - each event may halt, pulse the trigger output, or both.
// - a fetched address at or above the memory size is out of bounds.
// - the address of the previous instruction is frozen on halt.
// - four combiners each merge up to eight breakpoint events.
// - combiners take breakpoints, events and combiner outputs and may halt or pulse trigger out.
// - sequence members alone never act; only a finished sequence does.
// - a sequence runs from its lowest member to its highest.
// - latched and fires once every member has been seen.
// - a combiner output may be a member of another combiner.
// - trigger in has a selectable polarity and an optional filter.
// - trigger out has a selectable polarity, one-shot or event length.
`timescale 1ns/10ps
module evbrk_top #(
    parameter int PC_W = 15,
    parameter logic [15:0] PMEM_DEF = evbrk_pkg::PMEM_RST
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic pc_valid_i,
    input wire logic run_start_i,
    input wire logic master_clear_reset_pin_n_i,
    input wire logic external_trigger_input_i,
    input wire logic [evbrk_pkg::NUM_BP-1:0] bp_hit_i,
    output logic halt_req_o,
    output logic external_trigger_output_o,
    output logic irq_o
);
    import evbrk_pkg::*;

    if (PC_W < 1 || PC_W > 16) begin : g_bad_pc
        $error("PC_W must lie in 1..16");
    end

    localparam int SHOT_LEN = ONESHOT_CYC;

    function automatic logic [4:0] count_ones(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction

    logic [7:0] ctrl, next_ctrl;
    logic [5:0] ev_act, next_ev_act;
    logic [15:0] bp_act, next_bp_act;
    logic [15:0] pmem, next_pmem;
    logic [CMB_W-1:0] cmb_cfg [NUM_CMB];
    logic [CMB_W-1:0] next_cmb_cfg [NUM_CMB];
    logic [7:0] st, next_st;
    logic [7:0] mask, next_mask;
    logic force_q, next_force;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr, next_halt, next_irq, next_tout;
    logic [PC_W-1:0] last_pc, next_last_pc, prev_pc, next_prev_pc;
    logic tin_raw, tin_flt, next_tin_flt;
    logic [FILT_W-1:0] tin_cnt, next_tin_cnt;
    logic [NUM_EV-1:0] lvl, lvl_q, ev;
    logic [NUM_CMB-1:0] fires, cfg_wr, own_fire;
    logic [NUM_SRC-1:0] src, assigned;
    logic [NUM_BP+NUM_EV-1:0] lvl_all;
    logic [1:0] a_sel;
    logic halt_now, trig_now, trig_lvl, wr, rd_err;
    logic [31:0] rd;
    tout_state_t to_st, next_to_st;
    logic [SHOT_W-1:0] shot_cnt, next_shot_cnt;

    // ----------------------------------------
    // combiners
    // ----------------------------------------
    cmb_if cif [NUM_CMB] ();
    for (genvar g = 0; g < NUM_CMB; g++) begin : g_cmb
        assign cif[g].members = cmb_cfg[g][15:0];
        assign cif[g].mode_and = cmb_cfg[g][CMB_MODE];
        assign cif[g].src = src;
        assign cif[g].restart = run_start_i | cfg_wr[g];
        assign fires[g] = cif[g].fire;
        cmb_unit u_cmb (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .bus(cif[g])
        );
    end

    // ----------------------------------------
    // events and actions
    // ----------------------------------------
    always_comb begin
        tin_raw = external_trigger_input_i ^ ctrl[C_TIN_NEG];
        next_tin_flt = tin_flt;
        next_tin_cnt = '0;
        if (!ctrl[C_FILT_EN]) begin
            next_tin_flt = tin_raw;
        end else if (tin_raw != tin_flt) begin
            if (tin_cnt == FILT_W'(FILTER_CYC - 1)) begin
                next_tin_flt = tin_raw;
            end else begin
                next_tin_cnt = tin_cnt + 1'b1;
            end
        end
        lvl[0] = ~master_clear_reset_pin_n_i & ctrl[C_MASTER_CLEAR_RESET_PIN_EN];
        lvl[1] = pc_valid_i & (16'(pc_i) >= pmem) & ctrl[C_OOB_EN];
        lvl[2] = tin_flt & ctrl[C_TIN_EN];
        ev = lvl & ~lvl_q;
        lvl_all = {lvl, bp_hit_i};
        // combiner outputs feed back as members
        src = {fires, 1'b0, ev, bp_hit_i};
        assigned = '0;
        for (int g = 0; g < NUM_CMB; g++) begin
            assigned = assigned | cmb_cfg[g][15:0];
        end
        halt_now = 1'b0;
        trig_now = 1'b0;
        trig_lvl = 1'b0;
        a_sel = 2'h0;
        for (int i = 0; i < NUM_BP + NUM_EV; i++) begin
            if (i < NUM_BP) begin
                a_sel = bp_act[2*i +: 2];
            end else begin
                a_sel = ev_act[2*(i-NUM_BP) +: 2];
            end
            if (!assigned[i]) begin
                halt_now = halt_now | (src[i] & a_sel[ACT_HALT]);
                trig_now = trig_now | (src[i] & a_sel[ACT_TRIG]);
                trig_lvl = trig_lvl | (lvl_all[i] & a_sel[ACT_TRIG]);
            end
        end
        // combined output acts unless nested in another
        own_fire = fires & ~assigned[SRC_CMB +: NUM_CMB];
        for (int g = 0; g < NUM_CMB; g++) begin
            halt_now = halt_now | (own_fire[g] & cmb_cfg[g][CMB_ACT+ACT_HALT]);
            trig_now = trig_now | (own_fire[g] & cmb_cfg[g][CMB_ACT+ACT_TRIG]);
            trig_lvl = trig_lvl | (own_fire[g] & cmb_cfg[g][CMB_ACT+ACT_TRIG]);
        end
        next_halt = halt_now | (halt_req_o & ~run_start_i);
        next_last_pc = last_pc;
        next_prev_pc = prev_pc;
        if (pc_valid_i && !halt_req_o) begin
            next_prev_pc = last_pc;
            next_last_pc = pc_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            tin_flt <= 1'b0;
            tin_cnt <= '0;
            lvl_q <= '0;
            halt_req_o <= 1'b0;
            last_pc <= '0;
            prev_pc <= '0;
        end else begin
            tin_flt <= next_tin_flt;
            tin_cnt <= next_tin_cnt;
            lvl_q <= lvl;
            halt_req_o <= next_halt;
            last_pc <= next_last_pc;
            prev_pc <= next_prev_pc;
        end
    end

    // ----------------------------------------
    // apb registers
    // ----------------------------------------
    always_comb begin
        rd = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr_i == OFF_CTRL) begin
            rd = {24'h00_0000, ctrl};
        end else if (paddr_i == OFF_EV_ACT) begin
            rd = {26'h000_0000, ev_act};
        end else if (paddr_i == OFF_BP_ACT) begin
            rd = {16'h0000, bp_act};
        end else if (paddr_i == OFF_PMEM) begin
            rd = {16'h0000, pmem};
        end else if (paddr_i[7:4] == OFF_CMB0[7:4]) begin
            rd = 32'(cmb_cfg[paddr_i[3:2]]);
            rd_err = pwrite_i
                && count_ones(pwdata_i[15:0]) > 5'(MAX_MEMB);
        end else if (paddr_i == OFF_PREV_PC) begin
            rd = 32'(prev_pc);
        end else if (paddr_i == OFF_STATUS) begin
            rd = {24'h00_0000, st};
        end else if (paddr_i == OFF_MASK) begin
            rd = {24'h00_0000, mask};
        end else begin
            rd_err = 1'b1;
        end
        next_pready = psel_i & penable_i & ~pready_o;
        next_prdata = next_pready && !pwrite_i ? rd : 32'h0000_0000;
        next_pslverr = next_pready & rd_err;
        wr = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
        next_ctrl = ctrl;
        next_ev_act = ev_act;
        next_bp_act = bp_act;
        next_pmem = pmem;
        next_mask = mask;
        next_cmb_cfg = cmb_cfg;
        cfg_wr = '0;
        next_force = 1'b0;
        next_st = st;
        if (wr && paddr_i == OFF_CTRL) begin
            next_ctrl = pwdata_i[7:0];
            next_ctrl[C_FORCE] = 1'b0;
            next_force = pwdata_i[C_FORCE];
        end else if (wr && paddr_i == OFF_EV_ACT) begin
            next_ev_act = pwdata_i[5:0];
        end else if (wr && paddr_i == OFF_BP_ACT) begin
            next_bp_act = pwdata_i[15:0];
        end else if (wr && paddr_i == OFF_PMEM) begin
            next_pmem = pwdata_i[15:0];
        end else if (wr && paddr_i[7:4] == OFF_CMB0[7:4]) begin
            next_cmb_cfg[paddr_i[3:2]] = pwdata_i[CMB_W-1:0];
            cfg_wr[paddr_i[3:2]] = 1'b1;
        end else if (wr && paddr_i == OFF_STATUS) begin
            next_st = st & ~pwdata_i[7:0];
        end else if (wr && paddr_i == OFF_MASK) begin
            next_mask = pwdata_i[7:0];
        end
        // new events win over a clear in the same cycle
        next_st = next_st | {halt_now, fires, ev};
        next_irq = |(next_st & next_mask);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl <= CTRL_RST;
            ev_act <= EV_ACT_RST;
            bp_act <= BP_ACT_RST;
            pmem <= PMEM_DEF;
            mask <= MASK_RST;
            st <= 8'h00;
            force_q <= 1'b0;
            cmb_cfg <= '{default: CMB_RST};
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            ev_act <= next_ev_act;
            bp_act <= next_bp_act;
            pmem <= next_pmem;
            mask <= next_mask;
            st <= next_st;
            force_q <= next_force;
            cmb_cfg <= next_cmb_cfg;
            prdata_o <= next_prdata;
            pready_o <= next_pready;
            pslverr_o <= next_pslverr;
            irq_o <= next_irq;
        end
    end

    // ----------------------------------------
    // trigger output
    // ----------------------------------------
    always_comb begin
        next_to_st = to_st;
        next_shot_cnt = shot_cnt;
        case (to_st)
            TO_IDLE: begin
                if (force_q || (trig_now && ctrl[C_ONESHOT])) begin
                    next_to_st = TO_SHOT;
                    next_shot_cnt = SHOT_W'(ONESHOT_CYC - 1);
                end else if (trig_lvl && !ctrl[C_ONESHOT]) begin
                    next_to_st = TO_LEVEL;
                end
            end
            TO_SHOT: begin
                if (shot_cnt == '0) begin
                    next_to_st = TO_IDLE;
                end else begin
                    next_shot_cnt = shot_cnt - 1'b1;
                end
            end
            TO_LEVEL: begin
                if (!trig_lvl) begin
                    next_to_st = TO_IDLE;
                end
            end
            default: begin
                next_to_st = TO_IDLE;
            end
        endcase
        next_tout = (next_to_st != TO_IDLE) ^ next_ctrl[C_TOUT_NEG];
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            to_st <= TO_IDLE;
            shot_cnt <= '0;
            external_trigger_output_o <= 1'b0;
        end else begin
            to_st <= next_to_st;
            shot_cnt <= next_shot_cnt;
            external_trigger_output_o <= next_tout;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    chk_oob_flag: assert property (
        ctrl[C_OOB_EN] && pc_valid_i && 16'(pc_i) >= pmem && !lvl_q[1]
        |=> st[ST_EV+1])
        else $error("out-of-bounds fetch not flagged");
    chk_prev_hold: assert property (
        halt_req_o && !run_start_i |=> $stable(prev_pc))
        else $error("previous address moved while halted");
    chk_shot_len: assert property (
        $rose(to_st == TO_SHOT) |-> ##SHOT_LEN (to_st != TO_SHOT))
        else $error("one-shot width wrong");
    chk_tout_pol: assert property (
        external_trigger_output_o
        == ((to_st != TO_IDLE) ^ ctrl[C_TOUT_NEG]))
        else $error("trigger out level disagrees with state");
    chk_master_clear_reset_pin_halt: assert property (
        src[SRC_MASTER_CLEAR_RESET_PIN] && ev_act[ACT_HALT] && !assigned[SRC_MASTER_CLEAR_RESET_PIN]
        |=> halt_req_o)
        else $error("master clear halt not raised");
    chk_member_mute: assert property (
        $rose(halt_req_o) |-> $past(|(src[10:0] & ~assigned[10:0]))
        || $past(|fires))
        else $error("halt raised by a combiner member");
    chk_tin_filter: assert property (
        ctrl[C_FILT_EN] && $past(ctrl[C_FILT_EN]) && $changed(tin_flt)
        |-> $past(tin_cnt) == FILT_W'(FILTER_CYC - 1))
        else $error("filter passed a short pulse");
    cov_oneshot: cover property ($rose(to_st == TO_SHOT));
    cov_nested: cover property (src[SRC_CMB] && assigned[SRC_CMB]);
endmodule // evbrk_top

// ===== sim/core_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// emulated core: fetches, breakpoint hits, pins
// ----------------------------------------
module core_model (
    input wire logic clk_i,
    input wire logic halt_i,
    output logic [14:0] pc_o,
    output logic pc_valid_o,
    output logic [7:0] bp_hit_o,
    output logic master_clear_reset_pin_n_o,
    output logic external_trigger_input_o
);
    initial begin
        pc_o = 15'h0000;
        pc_valid_o = 1'b0;
        bp_hit_o = 8'h00;
        master_clear_reset_pin_n_o = 1'b1;
        external_trigger_input_o = 1'b0;
    end
    // a halted core fetches nothing; idle bus shows a changed pattern
    task automatic exec(input logic [14:0] pc);
        @(posedge clk_i);
        if (!halt_i) begin
            pc_o <= pc;
            pc_valid_o <= 1'b1;
        end
        @(posedge clk_i);
        pc_valid_o <= 1'b0;
        pc_o <= ~pc;
    endtask
    task automatic hit(input int b);
        @(posedge clk_i);
        bp_hit_o <= 8'h01 << b;
        @(posedge clk_i);
        bp_hit_o <= 8'h00;
    endtask
    task automatic pin(input int which, input logic lvl);
        @(posedge clk_i);
        if (which == 0) begin
            master_clear_reset_pin_n_o <= lvl;
        end else begin
            external_trigger_input_o <= lvl;
        end
    endtask
endmodule // core_model

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
    import evbrk_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel, penable, pwrite, run_start;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready, pslverr, halt, tout, irq, pc_valid, master_clear_reset_pin_n, tin;
    logic [14:0] pc;
    logic [7:0] bp;
    logic [32:0] expq[$];
    int num_errors = 0;
    int checked = 0;
    int n;
    int seq[5] = '{2, 0, 2, 1, 2};
    always #20 clk_i = ~clk_i;
    evbrk_top u_evbrk_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .pc_i(pc),
        .pc_valid_i(pc_valid), .run_start_i(run_start),
        .master_clear_reset_pin_n_i(master_clear_reset_pin_n),
        .external_trigger_input_i(tin), .bp_hit_i(bp),
        .halt_req_o(halt), .external_trigger_output_o(tout), .irq_o(irq));
    core_model u_core_model (.clk_i(clk_i), .halt_i(halt), .pc_o(pc),
        .pc_valid_o(pc_valid), .bp_hit_o(bp),
        .master_clear_reset_pin_n_o(master_clear_reset_pin_n),
        .external_trigger_input_o(tin));
    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic check(input logic [32:0] seen, input logic [32:0] exp,
                         input string what);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] exp);
        expq.push_back(exp);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic e = 1'b0);
        apb(1'b0, a, $urandom(), {e, d});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic e = 1'b0);
        apb(1'b1, a, d, {e, 32'h0000_0000});
    endtask
    task automatic wait_halt();
        n = 0;
        while (halt !== 1'b1 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        check(halt, 1'b1, "halt late");
        if (halt !== 1'b1) begin
            summarize();
        end
    endtask
    task automatic quiet();
        repeat (4) @(posedge clk_i);
        check(halt, 1'b0, "early halt");
    endtask
    task automatic resume();
        run_start <= 1'b1;
        @(posedge clk_i);
        run_start <= 1'b0;
        wr(OFF_STATUS, 32'h0000_00FF);
        repeat (3) @(posedge clk_i);
        check({halt, irq}, 2'b00, "resume");
    endtask
    // read answers are compared as they appear
    always @(posedge clk_i) begin
        if (rst_n_i && pready === 1'b1) begin
            if (expq.size() == 0) begin
                check(1'b1, 1'b0, "stray ready");
            end else begin
                check({pslverr, prdata}, expq.pop_front(), "apb");
            end
        end
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h73f1_ae6e));
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        run_start <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h0000_0000;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        check({halt, tout, irq}, 3'b000, "reset outputs");
        rd(OFF_PMEM, {16'h0000, PMEM_RST});
        rd(8'h40, 32'h0000_0000, 1'b1);
        wr(OFF_PMEM, 32'h0000_0100);
        wr(OFF_MASK, 32'h0000_0080);
        for (int s = 0; s < 3; s++) begin
            wr(OFF_CTRL, 32'h0000_00E0);
            wr(OFF_EV_ACT, 32'h1 << (2 * s));
            case (s)
                0: u_core_model.pin(0, 1'b0);
                1: begin
                    u_core_model.exec(15'($urandom_range(0, 254)));
                    u_core_model.exec(15'h00FF);
                    u_core_model.exec(15'h0100);
                end
                default: u_core_model.pin(1, 1'b1);
            endcase
            wait_halt();
            check(irq, 1'b1, "irq");
            rd(OFF_STATUS, 32'h80 | (32'h1 << s));
            if (s == 1) begin
                rd(OFF_PREV_PC, 32'h0000_00FF);
            end
            u_core_model.pin(0, 1'b1);
            u_core_model.pin(1, 1'b0);
            resume();
        end
        wr(OFF_CTRL, 32'h0000_0082);
        wr(OFF_EV_ACT, 32'h0000_0030);
        u_core_model.pin(1, 1'b1);
        u_core_model.pin(1, 1'b0);
        quiet();
        u_core_model.pin(1, 1'b1);
        wait_halt();
        check(tout, 1'b1, "level trigger");
        u_core_model.pin(1, 1'b0);
        repeat (8) @(posedge clk_i);
        check(tout, 1'b0, "level end");
        resume();
        wr(OFF_CTRL, 32'h0000_0081);
        wait_halt();
        resume();
        wr(OFF_CTRL, 32'h0000_002C);
        wr(OFF_EV_ACT, 32'h0000_0002);
        @(posedge clk_i);
        check(tout, 1'b1, "trigger idle");
        u_core_model.pin(0, 1'b0);
        n = 0;
        while (tout !== 1'b0 && n < 8) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 8) begin
            num_errors++;
            summarize();
        end
        n = 0;
        while (tout === 1'b0 && n < 60) begin
            @(posedge clk_i);
            n++;
        end
        check(33'(n), 33'(ONESHOT_CYC), "shot width");
        if (n >= 60) begin
            summarize();
        end
        check({halt, irq}, 2'b00, "trigger only");
        u_core_model.pin(0, 1'b1);
        wr(OFF_CTRL, 32'h0000_0010);
        @(posedge clk_i);
        check(tout, 1'b1, "forced pulse");
        rd(OFF_CTRL, 32'h0000_0000);
        wr(OFF_STATUS, 32'h0000_00FF);
        wr(OFF_BP_ACT, 32'h0000_0015);
        wr(OFF_CMB0, 32'h0002_0007);
        for (int i = 0; i < 5; i++) begin
            if (i == 4) begin
                u_core_model.hit(seq[i]);
                wait_halt();
            end else begin
                u_core_model.hit(seq[i]);
                quiet();
            end
        end
        rd(OFF_STATUS, 32'h0000_0088);
        resume();
        wr(OFF_CMB0 + 8'h04, 32'h0001_0018);
        wr(OFF_CMB0 + 8'h08, 32'h0003_2020);
        u_core_model.hit(3);
        resume();
        u_core_model.hit(5);
        u_core_model.hit(4);
        quiet();
        u_core_model.hit(3);
        wait_halt();
        rd(OFF_STATUS, 32'h0000_00B0);
        resume();
        wr(OFF_CMB0 + 8'h0C, 32'h0000_01FF, 1'b1);
        rd(OFF_CMB0 + 8'h0C, 32'h0000_0000);
        wr(OFF_CMB0 + 8'h0C, 32'h0000_00FF);
        rd(OFF_CMB0 + 8'h0C, 32'h0000_00FF);
        u_core_model.hit(0);
        quiet();
        repeat (2) @(posedge clk_i);
        summarize();
    end
endmodule // tb
